// ==== irf_defines.svh ====
/*
  constants for the interrupt window request filter: address-type codes,
  window prefix, fault codes, register offsets, control bits and event bits.
  assumes inclusion by bare name from the package and design files.
*/
`ifndef IRF_DEFINES_SVH
`define IRF_DEFINES_SVH

`define IRF_AT_UNTRANSLATED   2'h0
`define IRF_AT_TRANS_REQ      2'h1
`define IRF_AT_TRANSLATED     2'h2
`define IRF_WIN_PREFIX        12'hFEE
`define IRF_WIN_HI            31
`define IRF_WIN_LO            20
`define IRF_DW_ONE            10'h001
`define IRF_BE_NONE           4'h0
`define IRF_FLT_NONE          4'h0
`define IRF_FLT_IRQ_REMAP     4'h1
`define IRF_FLT_FIRST_STAGE   4'h4
`define IRF_FLT_SECOND_STAGE  4'h8
`define IRF_OFS_CTRL          4'h0
`define IRF_OFS_STATUS        4'h1
`define IRF_OFS_MASK          4'h2
`define IRF_OFS_P2P_BASE      4'h3
`define IRF_OFS_P2P_LIMIT     4'h4
`define IRF_OFS_COUNT         4'h5
`define IRF_CTRL_RESET        8'h01
`define IRF_CTRL_REMAP_EN     0
`define IRF_CTRL_P2P_EN       1
`define IRF_CTRL_P2P_RANGE    2
`define IRF_CTRL_ZERO_RD_OBF  3
`define IRF_OBF_DATA          32'h0000_0000
`define IRF_NUM_EVT           5
`define IRF_EVT_IRQ_FAULT     0
`define IRF_EVT_XLT_FAULT     1
`define IRF_EVT_UR            2
`define IRF_EVT_P2P_REFUSE    3
`define IRF_EVT_INTR          4

`endif

// ==== irf_filter.sv ====
/*
  interrupt window request filter: classifies upstream memory requests,
  answers fixed translations, blocks faults, forwards peers after
  translation, and keeps event status with masked interrupt.
  assumes one clock, synchronous inputs, a translation engine that
  answers a remap step with XLT_VALID, and a register port master that
  issues single-cycle strobes.
*/
// Our own choices: the address map and the strobed register port.
// Functional notes
// R01 - zero-length read without PASID into window completes, data obfuscated
// R02 - translation request without PASID into window answers R=0 W=1 U=1 S=0
// R03 - non-zero reads, atomics, non-one-dword writes into window are fault-blocked
// R04 - PASID requests into window go through normal translation
// R05 - pass-through PASID request into window is blocked
// R06 - translations landing in window blocked with first- or second-stage code
// R07 - translated requests with window address answered Unsupported Request
// R08 - peer requests decoded only on translated host physical address
// R09 - peer forwarding may be limited to a region or refused
// R10 - forwarded peer request with end-to-end CRC gets it recomputed
// R11 - address type codes: untranslated, translation request, translated
// R12 - reserved memory is never recognised by plain address decoding
// R13 - non-PASID window requests never go to DMA remapping
// R14 - one-dword non-PASID window writes go to interrupt path
// R15 - zero-length read is one dword with all byte enables clear
// R16 - window means bits 31:20 equal prefix and upper bits zero
`timescale 1ns/1ps
`include "irf_defines.svh"
module irf_filter (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              REQ_VALID,
  input  wire irf_pkg::irf_req_t REQ,
  input  wire logic              XLT_VALID,
  input  wire irf_pkg::irf_xlt_t XLT,
  input  wire logic [3:0]        REG_ADDR,
  input  wire logic [31:0]       REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic [31:0]            REG_RDATA,
  output logic                   DEC_VALID,
  output irf_pkg::irf_dec_t      DEC,
  output logic [3:0]             FAULT_CODE,
  output irf_pkg::irf_xent_t     XENT,
  output logic                   XLT_START,
  output logic [63:0]            FWD_ADDR,
  output logic                   FWD_VALID,
  output logic                   ECRC_RECALC,
  output logic [31:0]            CPL_DATA,
  output logic                   BUSY,
  output logic                   IRQ
);

  // decision state
  typedef enum logic [1:0] {
    IRF_ST_IDLE = 2'h1,
    IRF_ST_WAIT = 2'h2
  } irf_st_t;

  irf_st_t             st_reg;
  irf_st_t             st_next;
  irf_pkg::irf_req_t   held_reg;
  logic [7:0]          ctrl_reg;
  logic [`IRF_NUM_EVT-1:0] status_reg;
  logic [`IRF_NUM_EVT-1:0] mask_reg;
  logic [31:0]         p2p_base_reg;
  logic [31:0]         p2p_limit_reg;
  logic [31:0]         count_reg;
  logic                dec_valid_reg;
  irf_pkg::irf_dec_t   dec_reg;
  logic [3:0]          fault_reg;
  irf_pkg::irf_xent_t  xent_reg;
  logic                xlt_start_reg;
  logic [63:0]         fwd_addr_reg;
  logic                fwd_valid_reg;
  logic                ecrc_reg;
  logic [31:0]         cpl_data_reg;
  logic [31:0]         rdata_reg;
  logic                irq_reg;
  logic                busy_reg;

  // window and region checks on the incoming and translated addresses
  logic in_win_req;
  logic in_win_xlt;
  logic in_region_xlt;
  logic unused_region_req;

  irf_window_check u_req_chk (
    .addr      (REQ.addr),
    .base      (p2p_base_reg),
    .limit     (p2p_limit_reg),
    .in_window (in_win_req),
    .in_region (unused_region_req)
  ); // [R16]

  irf_window_check u_xlt_chk (
    .addr      (XLT.host_physical_address),
    .base      (p2p_base_reg),
    .limit     (p2p_limit_reg),
    .in_window (in_win_xlt),
    .in_region (in_region_xlt)
  ); // [R08]

  // request classification terms
  wire is_untr    = (REQ.at == `IRF_AT_UNTRANSLATED); // [R11]
  wire is_treq    = (REQ.at == `IRF_AT_TRANS_REQ);    // [R11]
  wire is_trd     = (REQ.at == `IRF_AT_TRANSLATED);   // [R11]
  wire is_zero_rd = (REQ.kind == irf_pkg::IRF_REQ_READ) && (REQ.len_dw == `IRF_DW_ONE) &&
                    (REQ.first_be == `IRF_BE_NONE);   // [R15]
  wire is_dw_wr   = (REQ.kind == irf_pkg::IRF_REQ_WRITE) && (REQ.len_dw == `IRF_DW_ONE);
  wire np_win     = !REQ.has_pasid && in_win_req;     // [R13]
  wire remap_en   = ctrl_reg[`IRF_CTRL_REMAP_EN];
  wire p2p_en     = ctrl_reg[`IRF_CTRL_P2P_EN];
  wire p2p_range  = ctrl_reg[`IRF_CTRL_P2P_RANGE];

  // immediate decision for a new request, or remap when translation is needed
  irf_pkg::irf_dec_t imm_dec;
  logic [3:0]        imm_fault;
  always_comb begin
    imm_dec   = irf_pkg::IRF_DEC_REMAP;
    imm_fault = `IRF_FLT_NONE;
    if (!(is_untr || is_treq || is_trd)) begin
      imm_dec = irf_pkg::IRF_DEC_UR;
    end else if (is_trd && in_win_req) begin
      imm_dec = irf_pkg::IRF_DEC_UR; // [R07]
    end else if (np_win && is_treq) begin
      imm_dec = irf_pkg::IRF_DEC_FIXED_XLT; // [R02]
    end else if (np_win && is_zero_rd) begin
      imm_dec = irf_pkg::IRF_DEC_ZERO_RD; // [R01] [R13]
    end else if (np_win && is_dw_wr) begin
      imm_dec = irf_pkg::IRF_DEC_INTR; // [R14]
    end else if (np_win) begin
      imm_dec   = irf_pkg::IRF_DEC_BLOCK; // [R03]
      imm_fault = `IRF_FLT_IRQ_REMAP;
    end else if (!remap_en || is_trd) begin
      imm_dec = irf_pkg::IRF_DEC_NONE; // passes with its own address
    end
  end

  // decision after the translation engine answers
  wire peer_ok = p2p_en && (!p2p_range || in_region_xlt); // [R09]
  irf_pkg::irf_dec_t xlt_dec;
  logic [3:0]        xlt_fault;
  always_comb begin
    xlt_dec   = irf_pkg::IRF_DEC_NONE;
    xlt_fault = `IRF_FLT_NONE;
    if (XLT.fault) begin
      xlt_dec = irf_pkg::IRF_DEC_BLOCK;
    end else if (held_reg.has_pasid && XLT.pass_through && in_win_xlt) begin
      xlt_dec   = irf_pkg::IRF_DEC_BLOCK; // [R05]
      xlt_fault = `IRF_FLT_SECOND_STAGE;
    end else if (in_win_xlt) begin
      xlt_dec   = irf_pkg::IRF_DEC_BLOCK; // [R06]
      xlt_fault = XLT.first_stage ? `IRF_FLT_FIRST_STAGE : `IRF_FLT_SECOND_STAGE;
    end else if (XLT.peer && !peer_ok) begin
      xlt_dec = irf_pkg::IRF_DEC_BLOCK; // [R09]
    end
  end

  // next state
  wire take_req  = (st_reg == IRF_ST_IDLE) && REQ_VALID;
  wire need_xlt  = take_req && (imm_dec == irf_pkg::IRF_DEC_REMAP); // [R04]
  wire xlt_done  = (st_reg == IRF_ST_WAIT) && XLT_VALID;
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      IRF_ST_IDLE: if (need_xlt) st_next = IRF_ST_WAIT;
      IRF_ST_WAIT: if (XLT_VALID) st_next = IRF_ST_IDLE;
    endcase
  end

  // event pulses
  logic [`IRF_NUM_EVT-1:0] evt;
  wire new_dec = take_req && !need_xlt;
  assign evt[`IRF_EVT_IRQ_FAULT]  = new_dec && (imm_dec == irf_pkg::IRF_DEC_BLOCK);
  assign evt[`IRF_EVT_XLT_FAULT]  = xlt_done && (xlt_dec == irf_pkg::IRF_DEC_BLOCK);
  assign evt[`IRF_EVT_UR]         = new_dec && (imm_dec == irf_pkg::IRF_DEC_UR);
  assign evt[`IRF_EVT_P2P_REFUSE] = xlt_done && XLT.peer && !peer_ok;
  assign evt[`IRF_EVT_INTR]       = new_dec && (imm_dec == irf_pkg::IRF_DEC_INTR);

  // register decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction
  wire wr_ctrl   = REG_WR && hit(REG_ADDR, `IRF_OFS_CTRL);
  wire wr_status = REG_WR && hit(REG_ADDR, `IRF_OFS_STATUS);
  wire wr_mask   = REG_WR && hit(REG_ADDR, `IRF_OFS_MASK);
  wire wr_base   = REG_WR && hit(REG_ADDR, `IRF_OFS_P2P_BASE);
  wire wr_limit  = REG_WR && hit(REG_ADDR, `IRF_OFS_P2P_LIMIT);
  wire [`IRF_NUM_EVT-1:0] w1c = wr_status ? REG_WDATA[`IRF_NUM_EVT-1:0] : '0;
  // set wins over write-one-to-clear
  wire [`IRF_NUM_EVT-1:0] status_next = (status_reg & ~w1c) | evt;
  wire [31:0] rd_mux =
    hit(REG_ADDR, `IRF_OFS_CTRL)      ? {24'h000000, ctrl_reg} :
    hit(REG_ADDR, `IRF_OFS_STATUS)    ? {27'h0000000, status_reg} :
    hit(REG_ADDR, `IRF_OFS_MASK)      ? {27'h0000000, mask_reg} :
    hit(REG_ADDR, `IRF_OFS_P2P_BASE)  ? p2p_base_reg :
    hit(REG_ADDR, `IRF_OFS_P2P_LIMIT) ? p2p_limit_reg :
    hit(REG_ADDR, `IRF_OFS_COUNT)     ? count_reg : 32'h0000_0000;

  // outputs chosen for the cycle after a decision
  wire        out_valid = new_dec || xlt_done;
  wire irf_pkg::irf_dec_t out_dec = xlt_done ? xlt_dec : imm_dec;
  wire [3:0]  out_fault = xlt_done ? xlt_fault : imm_fault;
  wire        fwd_go    = xlt_done && (xlt_dec == irf_pkg::IRF_DEC_NONE);
  wire [31:0] cpl_next  = ctrl_reg[`IRF_CTRL_ZERO_RD_OBF] ? `IRF_OBF_DATA : count_reg; // [R01]
  wire irf_pkg::irf_xent_t fixed_ent = '{r: 1'b0, w: 1'b1, u: 1'b1, s: 1'b0}; // [R02]

  // state, request hold and registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg        <= IRF_ST_IDLE;
      held_reg      <= '0;
      ctrl_reg      <= `IRF_CTRL_RESET;
      status_reg    <= '0;
      mask_reg      <= '0;
      p2p_base_reg  <= 32'h0000_0000;
      p2p_limit_reg <= 32'h0000_0000;
      count_reg     <= 32'h0000_0000;
      busy_reg      <= 1'b0;
    end else begin
      st_reg     <= st_next;
      busy_reg   <= (st_next == IRF_ST_WAIT);
      status_reg <= status_next;
      if (take_req) held_reg <= REQ;
      if (wr_ctrl) ctrl_reg <= REG_WDATA[7:0];
      if (wr_mask) mask_reg <= REG_WDATA[`IRF_NUM_EVT-1:0];
      if (wr_base) p2p_base_reg <= REG_WDATA;
      if (wr_limit) p2p_limit_reg <= REG_WDATA;
      if (out_valid) count_reg <= count_reg + 32'h0000_0001;
    end
  end

  // registered outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dec_valid_reg <= 1'b0;
      dec_reg       <= irf_pkg::IRF_DEC_NONE;
      fault_reg     <= `IRF_FLT_NONE;
      xent_reg      <= '0;
      xlt_start_reg <= 1'b0;
      fwd_addr_reg  <= 64'h0000_0000_0000_0000;
      fwd_valid_reg <= 1'b0;
      ecrc_reg      <= 1'b0;
      cpl_data_reg  <= 32'h0000_0000;
      rdata_reg     <= 32'h0000_0000;
      irq_reg       <= 1'b0;
    end else begin
      dec_valid_reg <= out_valid;
      dec_reg       <= out_dec;
      fault_reg     <= out_fault;
      xent_reg      <= (new_dec && imm_dec == irf_pkg::IRF_DEC_FIXED_XLT) ? fixed_ent : '0;
      xlt_start_reg <= need_xlt;
      fwd_addr_reg  <= fwd_go ? XLT.host_physical_address : 64'h0000_0000_0000_0000; // [R08]
      fwd_valid_reg <= fwd_go && XLT.peer;                          // [R08]
      ecrc_reg      <= fwd_go && XLT.peer && held_reg.ecrc_present; // [R10]
      cpl_data_reg  <= (new_dec && imm_dec == irf_pkg::IRF_DEC_ZERO_RD) ? cpl_next : '0;
      rdata_reg     <= REG_RD ? rd_mux : 32'h0000_0000;
      irq_reg       <= |(status_next & mask_reg);
    end
  end

  // reserved memory is never matched by address here; only the window and the peer region are
  assign REG_RDATA   = rdata_reg; // [R12]
  assign DEC_VALID   = dec_valid_reg;
  assign DEC         = dec_reg;
  assign FAULT_CODE  = fault_reg;
  assign XENT        = xent_reg;
  assign XLT_START   = xlt_start_reg;
  assign FWD_ADDR    = fwd_addr_reg;
  assign FWD_VALID   = fwd_valid_reg;
  assign ECRC_RECALC = ecrc_reg;
  assign CPL_DATA    = cpl_data_reg;
  assign BUSY        = busy_reg;
  assign IRQ         = irq_reg;

  // checks
  a_fixed_xlt_ent: assert property (@(posedge CLK) disable iff (!RST_N) // [R02]
    (new_dec && imm_dec == irf_pkg::IRF_DEC_FIXED_XLT) |=> (XENT == 4'h6))
    else $error("fixed translation entry wrong");

  a_np_win_noremap: assert property (@(posedge CLK) disable iff (!RST_N) // [R13]
    (take_req && !REQ.has_pasid && in_win_req) |=> !XLT_START)
    else $error("window request sent to remap");

  a_bad_win_block: assert property (@(posedge CLK) disable iff (!RST_N) // [R03]
    (take_req && np_win && is_untr && REQ.kind == irf_pkg::IRF_REQ_ATOMIC)
    |=> (DEC == irf_pkg::IRF_DEC_BLOCK && FAULT_CODE == `IRF_FLT_IRQ_REMAP))
    else $error("atomic into window not blocked");

  a_long_write_block: assert property (@(posedge CLK) disable iff (!RST_N) // [R03]
    (take_req && np_win && is_untr && REQ.kind == irf_pkg::IRF_REQ_WRITE && !is_dw_wr)
    |=> (DEC == irf_pkg::IRF_DEC_BLOCK && FAULT_CODE == `IRF_FLT_IRQ_REMAP))
    else $error("long write into window not blocked");

  a_trd_win_ur: assert property (@(posedge CLK) disable iff (!RST_N) // [R07]
    (take_req && is_trd && in_win_req) |=> (DEC_VALID && DEC == irf_pkg::IRF_DEC_UR))
    else $error("translated window request not UR");

  a_rsvd_type_ur: assert property (@(posedge CLK) disable iff (!RST_N) // [R11]
    (take_req && !(is_untr || is_treq || is_trd))
    |=> (DEC_VALID && DEC == irf_pkg::IRF_DEC_UR))
    else $error("reserved address type not UR");

  a_intr_path: assert property (@(posedge CLK) disable iff (!RST_N) // [R14]
    (take_req && np_win && is_dw_wr && is_untr) |=> (DEC == irf_pkg::IRF_DEC_INTR))
    else $error("dword write not sent as interrupt");

  a_pasid_remap: assert property (@(posedge CLK) disable iff (!RST_N) // [R04]
    (take_req && REQ.has_pasid && is_untr && remap_en) |=> (XLT_START && BUSY))
    else $error("pasid window request not translated");

  a_xlt_win_block: assert property (@(posedge CLK) disable iff (!RST_N) // [R06]
    (xlt_done && !XLT.fault && in_win_xlt && XLT.first_stage && !XLT.pass_through)
    |=> (DEC == irf_pkg::IRF_DEC_BLOCK && FAULT_CODE == `IRF_FLT_FIRST_STAGE))
    else $error("translated window address not blocked");

  a_pt_pasid_block: assert property (@(posedge CLK) disable iff (!RST_N) // [R05]
    (xlt_done && !XLT.fault && held_reg.has_pasid && XLT.pass_through && in_win_xlt)
    |=> (DEC == irf_pkg::IRF_DEC_BLOCK && FAULT_CODE == `IRF_FLT_SECOND_STAGE))
    else $error("pass-through window request not blocked");

  a_peer_refused: assert property (@(posedge CLK) disable iff (!RST_N) // [R09]
    (xlt_done && !XLT.fault && !in_win_xlt && XLT.peer && !peer_ok)
    |=> (DEC == irf_pkg::IRF_DEC_BLOCK && !FWD_VALID))
    else $error("refused peer request forwarded");

  a_peer_fwd_addr: assert property (@(posedge CLK) disable iff (!RST_N) // [R08]
    FWD_VALID |-> (FWD_ADDR == $past(XLT.host_physical_address)))
    else $error("peer forward not on translated address");

  a_ecrc_with_fwd: assert property (@(posedge CLK) disable iff (!RST_N) // [R10]
    ECRC_RECALC |-> FWD_VALID)
    else $error("crc recompute without forward");

  a_ecrc_recompute: assert property (@(posedge CLK) disable iff (!RST_N) // [R10]
    (fwd_go && XLT.peer && held_reg.ecrc_present) |=> (ECRC_RECALC && FWD_VALID))
    else $error("crc not recomputed on forward");

  a_zero_rd_done: assert property (@(posedge CLK) disable iff (!RST_N) // [R01]
    (take_req && np_win && is_zero_rd && is_untr) |=> (DEC == irf_pkg::IRF_DEC_ZERO_RD))
    else $error("zero-length read not completed");

  a_zero_rd_data: assert property (@(posedge CLK) disable iff (!RST_N) // [R01]
    (new_dec && imm_dec == irf_pkg::IRF_DEC_ZERO_RD && ctrl_reg[`IRF_CTRL_ZERO_RD_OBF])
    |=> (CPL_DATA == `IRF_OBF_DATA))
    else $error("zero-length read data not obfuscated");
endmodule

// ==== irf_pkg.sv ====
/*
  types for the interrupt window request filter.
  assumes irf_defines.svh is reachable by bare name.
*/
`include "irf_defines.svh"
package irf_pkg;

  typedef enum logic [1:0] {
    IRF_REQ_READ   = 2'h0,
    IRF_REQ_WRITE  = 2'h1,
    IRF_REQ_ATOMIC = 2'h2
  } irf_kind_t;

  typedef enum logic [6:0] {
    IRF_DEC_NONE      = 7'h01,
    IRF_DEC_REMAP     = 7'h02,
    IRF_DEC_ZERO_RD   = 7'h04,
    IRF_DEC_FIXED_XLT = 7'h08,
    IRF_DEC_INTR      = 7'h10,
    IRF_DEC_BLOCK     = 7'h20,
    IRF_DEC_UR        = 7'h40
  } irf_dec_t;

  // upstream request header fields of interest
  typedef struct packed {
    irf_kind_t   kind;
    logic [1:0]  at;
    logic        has_pasid;
    logic [63:0] addr;
    logic [9:0]  len_dw;
    logic [3:0]  first_be;
    logic        ecrc_present;
  } irf_req_t;

  // result coming back from the translation engine
  typedef struct packed {
    logic [63:0] host_physical_address;
    logic        pass_through;
    logic        first_stage;
    logic        fault;
    logic        peer;
  } irf_xlt_t;

  // fixed translation completion entry
  typedef struct packed {
    logic r;
    logic w;
    logic u;
    logic s;
  } irf_xent_t;

endpackage

// ==== irf_window_check.sv ====
/*
  small decoder: tells whether an address lies in the interrupt window
  and whether it lies inside a programmed peer forwarding region.
  assumes pure combinational use inside the filter.
*/
`timescale 1ns/1ps
`include "irf_defines.svh"
module irf_window_check (
  input  wire logic [63:0] addr,
  input  wire logic [31:0] base,
  input  wire logic [31:0] limit,
  output logic             in_window,
  output logic             in_region
);
  // window prefix in bits 31:20, all upper bits zero
  assign in_window = (addr[63:32] == 32'h0000_0000) &&
                     (addr[`IRF_WIN_HI:`IRF_WIN_LO] == `IRF_WIN_PREFIX);
  // peer region on lower address word compare against base and limit, upper word zero
  assign in_region = (addr[63:32] == 32'h0000_0000) &&
                     (addr[31:0] >= base) && (addr[31:0] <= limit);
endmodule

// ==== irf_xlt_model.sv ====
/*
  translation engine stand-in for the interrupt window request filter.
  assumes the bench sets LAT and RSP before the filter raises XLT_START.
*/
`timescale 1ns/1ps
module irf_xlt_model (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              XLT_START,
  input  wire logic [3:0]        LAT,
  input  wire irf_pkg::irf_xlt_t RSP,
  output logic                   XLT_VALID,
  output irf_pkg::irf_xlt_t      XLT
);
  logic [3:0] cnt_reg;
  logic       act_reg;

  // waits LAT cycles after a start, answers once, scrambles result otherwise
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_reg   <= 4'h0;
      act_reg   <= 1'b0;
      XLT_VALID <= 1'b0;
      XLT       <= '0;
    end else begin
      XLT_VALID <= 1'b0;
      XLT       <= irf_pkg::irf_xlt_t'(~XLT);
      if (XLT_START) begin
        act_reg <= 1'b1;
        cnt_reg <= LAT;
      end else if (act_reg && cnt_reg == 4'h0) begin
        act_reg   <= 1'b0;
        XLT_VALID <= 1'b1;
        XLT       <= RSP;
      end else if (act_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule

// ==== test_interrupt_range_request_filter.sv ====
/*
  self-checking bench for the interrupt window request filter.
  assumes irf_pkg compiled first and a translation engine model.
*/
`timescale 1ns/1ps
`include "irf_defines.svh"
module test_interrupt_range_request_filter;
  typedef struct packed {
    logic       any;
    logic [6:0] dec;
    logic [3:0] flt;
    logic [3:0] xe;
  } irf_note_t;
  logic               CLK;
  logic               RST_N;
  logic               REQ_VALID;
  irf_pkg::irf_req_t  REQ;
  logic               XLT_VALID;
  irf_pkg::irf_xlt_t  XLT;
  logic [3:0]         REG_ADDR;
  logic [31:0]        REG_WDATA;
  logic               REG_WR;
  logic               REG_RD;
  logic [31:0]        REG_RDATA;
  logic               DEC_VALID;
  irf_pkg::irf_dec_t  DEC;
  logic [3:0]         FAULT_CODE;
  irf_pkg::irf_xent_t XENT;
  logic               XLT_START;
  logic [63:0]        FWD_ADDR;
  logic               FWD_VALID;
  logic               ECRC_RECALC;
  logic [31:0]        CPL_DATA;
  logic               BUSY;
  logic               IRQ;
  logic [3:0]         lat;
  irf_pkg::irf_xlt_t  rsp;
  irf_note_t          exp_q[$];
  logic [31:0]        rd_q[$];
  logic [64:0]        fwd_q[$];
  irf_note_t          nt;
  logic [64:0]        fq;
  logic               rd_pend = 1'b0;
  int                 xs_cnt = 0;
  int                 err_count = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
  int                 s;

  irf_filter u_irf_filter (.CLK(CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .XLT_VALID(XLT_VALID), .XLT(XLT), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .DEC_VALID(DEC_VALID),
    .DEC(DEC), .FAULT_CODE(FAULT_CODE), .XENT(XENT), .XLT_START(XLT_START),
    .FWD_ADDR(FWD_ADDR), .FWD_VALID(FWD_VALID), .ECRC_RECALC(ECRC_RECALC),
    .CPL_DATA(CPL_DATA), .BUSY(BUSY), .IRQ(IRQ));
  irf_xlt_model u_irf_xlt_model (.CLK(CLK), .RST_N(RST_N), .XLT_START(XLT_START),
    .LAT(lat), .RSP(rsp), .XLT_VALID(XLT_VALID), .XLT(XLT));

  // clock
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // register bus cycles
  task wr(input logic [3:0] a, input logic [31:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    @(posedge CLK);
  endtask

  task rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(posedge CLK);
  endtask

  // request side: held until an edge sees BUSY low
  task send(input irf_pkg::irf_kind_t k, input logic [1:0] at, input logic p,
            input logic [63:0] a, input logic [9:0] n, input logic [3:0] be, input logic e);
    while (BUSY !== 1'b0) @(posedge CLK);
    REQ <= '{k, at, p, a, n, be, e};
    REQ_VALID <= 1'b1;
    @(posedge CLK);
  endtask

  task idle();
    REQ_VALID <= 1'b0;
    REQ <= irf_pkg::irf_req_t'(~REQ);
  endtask

  task ex(input logic [6:0] d, input logic [3:0] f, input logic [3:0] x);
    exp_q.push_back('{d == 7'h00, d, f, x});
  endtask

  task drain();
    for (int i = 0; i < 60 && (exp_q.size() > 0 || BUSY !== 1'b0); i++) @(posedge CLK);
    @(posedge CLK);
  endtask

  function logic [63:0] win();
    return {32'h0, `IRF_WIN_PREFIX, 20'($urandom())};
  endfunction

  // one request through the translation engine
  task rmp(input logic p, input logic [1:0] at, input logic [63:0] a, input logic e,
           input irf_pkg::irf_xlt_t r, input logic [6:0] d, input logic [3:0] f);
    int s0;
    drain();
    s0 = xs_cnt;
    rsp <= r;
    lat <= 4'($urandom_range(0, 7));
    ex(d, f, 4'h0);
    if (r.peer && d == 7'h01) fwd_q.push_back({e, r.host_physical_address});
    if (at == 2'h1) send(irf_pkg::IRF_REQ_READ, at, p, a, 10'h2, 4'hF, e);
    else send(irf_pkg::IRF_REQ_WRITE, at, p, a, 10'h1, 4'hF, e);
    idle();
    drain();
    chk(xs_cnt - s0, 1);
  endtask

  // monitor: oldest note against each result
  always @(posedge CLK) begin
    rd_pend <= REG_RD;
    if (rd_pend) chk(REG_RDATA, rd_q.pop_front());
    if (XLT_START === 1'b1) xs_cnt++;
    if (DEC_VALID === 1'b1) begin
      chk(exp_q.size() != 0, 1);
      nt = exp_q.pop_front();
      if (!nt.any) chk(DEC, nt.dec);
      if (!nt.any) chk(FAULT_CODE, nt.flt);
      if (!nt.any) chk(XENT, nt.xe);
      if (DEC === irf_pkg::IRF_DEC_ZERO_RD) chk(CPL_DATA, `IRF_OBF_DATA);
    end
    if (FWD_VALID === 1'b1) begin
      fq = fwd_q.pop_front();
      chk(FWD_ADDR, fq[63:0]);
      chk(ECRC_RECALC, fq[64]);
    end
  end

  // hang guard
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      results();
    end
  end

  // main sequence
  initial begin
    RST_N = 1'b0;
    REQ_VALID = 1'b0;
    REQ = '0;
    REG_ADDR = 4'h0;
    REG_WDATA = 32'h0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    lat = 4'h0;
    rsp = '0;
    void'($urandom(32'h8ED073A0));
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    rd(`IRF_OFS_CTRL, 32'(`IRF_CTRL_RESET));
    wr(4'hF, $urandom());
    rd(4'hF, 32'h0);
    wr(`IRF_OFS_CTRL, 32'h0);
    s = xs_cnt;
    ex(7'h01, 4'h0, 4'h0);
    send(irf_pkg::IRF_REQ_READ, 2'h0, 1'b0, 64'h1000, 10'h1, 4'hF, 1'b0);
    idle();
    drain();
    chk(xs_cnt - s, 0);
    wr(`IRF_OFS_CTRL, 32'h9);
    // back-to-back requests without PASID: window requests, then a reserved address type
    s = xs_cnt;
    ex(7'h04, 4'h0, 4'h0);
    send(irf_pkg::IRF_REQ_READ, 2'h0, 1'b0, win(), 10'h1, 4'h0, 1'b0);
    ex(7'h08, 4'h0, 4'h6);
    send(irf_pkg::IRF_REQ_READ, 2'h1, 1'b0, win(), 10'h2, 4'hF, 1'b0);
    ex(7'h20, 4'h1, 4'h0);
    send(irf_pkg::IRF_REQ_READ, 2'h0, 1'b0, win(), 10'h1, 4'hF, 1'b0);
    ex(7'h20, 4'h1, 4'h0);
    send(irf_pkg::IRF_REQ_ATOMIC, 2'h0, 1'b0, win(), 10'h1, 4'hF, 1'b0);
    ex(7'h20, 4'h1, 4'h0);
    send(irf_pkg::IRF_REQ_WRITE, 2'h0, 1'b0, win(), 10'h2, 4'hF, 1'b0);
    ex(7'h10, 4'h0, 4'h0);
    send(irf_pkg::IRF_REQ_WRITE, 2'h0, 1'b0, win(), 10'h1, 4'hF, 1'b0);
    ex(7'h40, 4'h0, 4'h0);
    send(irf_pkg::IRF_REQ_READ, 2'h2, 1'b0, win(), 10'h1, 4'hF, 1'b0);
    ex(7'h40, 4'h0, 4'h0);
    send(irf_pkg::IRF_REQ_READ, 2'h3, 1'b0, 64'h2000, 10'h1, 4'hF, 1'b0);
    idle();
    drain();
    chk(xs_cnt - s, 0);
    // requests that go through translation
    rmp(1'b1, 2'h0, win(), 1'b0, '{64'h1000_0000, 1'b0, 1'b0, 1'b0, 1'b0}, 7'h01, 4'h0);
    rmp(1'b1, 2'h0, win(), 1'b0, '{win(), 1'b1, 1'b0, 1'b0, 1'b0}, 7'h20, 4'h8);
    rmp(1'b0, 2'h0, 64'h1_FEE0_0000, 1'b0, '{win(), 1'b0, 1'b1, 1'b0, 1'b0}, 7'h20, 4'h4);
    rmp(1'b0, 2'h1, 64'h3000, 1'b0, '{win(), 1'b0, 1'b0, 1'b0, 1'b0}, 7'h20, 4'h8);
    rmp(1'b0, 2'h0, 64'h5000, 1'b0, '{64'h6000, 1'b0, 1'b0, 1'b1, 1'b0}, 7'h20, 4'h0);
    // peer forwarding, region restricted then refused
    wr(`IRF_OFS_P2P_BASE, 32'h8000_0000);
    wr(`IRF_OFS_P2P_LIMIT, 32'h8FFF_FFFF);
    wr(`IRF_OFS_CTRL, 32'hF);
    wr(`IRF_OFS_STATUS, 32'h1F);
    rmp(1'b0, 2'h0, 64'h4000_1000, 1'b1, '{64'h8000_1000, 1'b0, 1'b0, 1'b0, 1'b1}, 7'h01, 4'h0);
    rmp(1'b0, 2'h0, 64'h4000_2000, 1'b0, '{64'h8000_2000, 1'b0, 1'b0, 1'b0, 1'b1}, 7'h01, 4'h0);
    rmp(1'b0, 2'h0, 64'h4000_3000, 1'b1, '{64'h9000_0000, 1'b0, 1'b0, 1'b0, 1'b1}, 7'h20, 4'h0);
    rd(`IRF_OFS_STATUS, 32'hA);
    wr(`IRF_OFS_STATUS, 32'h8);
    wr(`IRF_OFS_CTRL, 32'h9);
    rmp(1'b0, 2'h0, 64'h4000_4000, 1'b0, '{64'h8000_4000, 1'b0, 1'b0, 1'b0, 1'b1}, 7'h20, 4'h0);
    rd(`IRF_OFS_STATUS, 32'hA);
    // interrupt: masked, unmasked, cleared
    wr(`IRF_OFS_MASK, 32'h10);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b0);
    wr(`IRF_OFS_MASK, 32'h8);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b1);
    wr(`IRF_OFS_STATUS, 32'h8);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b0);
    results();
  end
endmodule
